// file: rtl/tsei_pkg.sv
// Package of constants and types for the split-mode timer event logic.
package tsei_pkg;
  localparam int CW = 16;
  // Flag and enable bit positions.
  localparam int FLAG_WRAP = 0;
  localparam int FLAG_HIGH_BYTE_UNDERFLOW = 1;
  localparam int FLAG_COMPARE0_IRQ = 4;
  localparam int FLAG_CMP1 = 5;
  localparam int FLAG_CMP2 = 6;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [2:0] PRESCALE_RST = 3'h0;
  localparam logic [15:0] FLOOR = 16'h0000;
  // Input A actions.
  typedef enum logic [2:0] {
    A_NONE = 3'h0, A_RISE = 3'h1, A_ANY = 3'h2, A_HIGH = 3'h3, A_DIR = 3'h4
  } tsei_act_a_t;
  // Input B actions.
  typedef enum logic [2:0] {
    B_NONE = 3'h0, B_DIR = 3'h3, B_RRISE = 3'h4, B_RANY = 3'h5,
    B_RHIGH = 3'h6
  } tsei_act_b_t;
  typedef struct packed {
    logic [2:0] input_b_action;
    logic       input_b_enable;
    logic [2:0] input_a_action;
    logic       input_a_enable;
  } tsei_event_control_reg_t;
  typedef struct packed {
    logic       wrap;
    logic       high_underflow;
    logic [2:0] compare;
  } tsei_events_t;
endpackage

// file: rtl/tsei_prescale.sv
// Prescaler that turns the peripheral clock into count ticks.
`timescale 1ns/1ns
`default_nettype none
module tsei_prescale
  import tsei_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       run,
  input  wire logic [2:0] prescale_select,
  // One-cycle tick.
  output logic            tick
);
  logic [9:0] div;
  logic [9:0] next_div;
  // Division codes 0..7 map to 1,2,4,8,16,64,256,1024.
  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: div_mask = 10'h000;
      3'h1: div_mask = 10'h001;
      3'h2: div_mask = 10'h003;
      3'h3: div_mask = 10'h007;
      3'h4: div_mask = 10'h00f;
      3'h5: div_mask = 10'h03f;
      3'h6: div_mask = 10'h0ff;
      default: div_mask = 10'h3ff;
    endcase
  endfunction
  assign tick = run &&
                ((div & div_mask(prescale_select)) ==
                 div_mask(prescale_select));
  always_comb begin
    next_div = run ? div + 10'h001 : 10'h000;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 10'h000;
    end else begin
      div <= next_div;
    end
  end
endmodule
`default_nettype wire

// file: rtl/tsei_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ns
`default_nettype none
module tsei_sync (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Raw and filtered level.
  input  wire logic raw,
  output logic      level
);
  logic [2:0] stage;
  logic       next_level;
  always_comb begin
    next_level = level;
    if (stage[1] == stage[2]) begin
      next_level = stage[1];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= {stage[1:0], raw};
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// file: rtl/tsei_top.sv
// Split-capable timer core with events, inputs and interrupt flags.
`timescale 1ns/1ns
`default_nettype none
module tsei_top
  import tsei_pkg::*;
(
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Control.
  input  wire logic         enable,
  input  wire logic [2:0]   prescale_select,
  input  wire logic         dual_counter_enable,
  input  wire logic         count_down,
  input  wire logic         reset_cmd,
  input  wire tsei_event_control_reg_t event_control_reg,
  // Period and compare values.
  input  wire logic [15:0]  period,
  input  wire logic [15:0]  compare0_irq,
  input  wire logic [15:0]  cmp1,
  input  wire logic [15:0]  cmp2,
  // Event inputs from the routing network.
  input  wire logic         event_input_a,
  input  wire logic         event_input_b,
  // Interrupt enables and flag clear strobes (write one to clear).
  input  wire logic [7:0]   irq_enable_reg,
  input  wire logic [7:0]   flag_clear,
  // Status.
  output logic [15:0]       counter_value,
  output logic              counting_down,
  output logic [7:0]        irq_flag_reg,
  output logic [7:0]        irq_request,
  // Event pulses.
  output tsei_events_t      events
);
  logic         lvl_a;
  logic         lvl_b;
  logic         prev_a;
  logic         prev_b;
  logic         tick;
  logic [15:0]  next_cnt;
  logic         next_dir;
  logic [7:0]   next_flags;
  logic [7:0]   cond;
  tsei_events_t next_events;

  tsei_sync u_sync_a (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .raw      (event_input_a),
    .level    (lvl_a)
  );
  tsei_sync u_sync_b (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .raw      (event_input_b),
    .level    (lvl_b)
  );
  tsei_prescale u_pre (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .run             (enable),
    .prescale_select (prescale_select),
    .tick            (tick)
  );

  // ************************************************************
  // Event input decode and counting
  // ************************************************************
  logic ev_on;
  logic a_en;
  logic b_en;
  logic a_rise;
  logic a_any;
  logic b_rise;
  logic b_any;
  logic cnt_step;
  logic restart;
  logic dir_a;
  logic dir_b;
  logic do_count;
  logic [7:0] lo;
  logic [7:0] hi;
  assign ev_on  = !dual_counter_enable;
  assign a_en   = ev_on && event_control_reg.input_a_enable;
  assign b_en   = ev_on && event_control_reg.input_b_enable;
  assign a_rise = lvl_a && !prev_a;
  assign a_any  = lvl_a != prev_a;
  assign b_rise = lvl_b && !prev_b;
  assign b_any  = lvl_b != prev_b;
  assign dir_a  = a_en && event_control_reg.input_a_action == A_DIR;
  assign dir_b  = b_en && event_control_reg.input_b_action == B_DIR;
  assign lo     = counter_value[7:0];
  assign hi     = counter_value[15:8];

  always_comb begin
    cnt_step = 1'b0;
    restart  = 1'b0;
    if (a_en) begin
      case (event_control_reg.input_a_action)
        A_RISE:  cnt_step = a_rise;
        A_ANY:   cnt_step = a_any;
        A_HIGH:  cnt_step = lvl_a;
        default: cnt_step = 1'b0;
      endcase
    end
    if (b_en) begin
      case (event_control_reg.input_b_action)
        B_RRISE: restart = b_rise;
        B_RANY:  restart = b_any;
        B_RHIGH: restart = lvl_b;
        default: restart = 1'b0;
      endcase
    end
  end

  // Counting on events replaces clock ticks when A selects a count action.
  always_comb begin
    if (a_en && event_control_reg.input_a_action != A_DIR &&
        event_control_reg.input_a_action != A_NONE) begin
      do_count = enable && cnt_step;
    end else begin
      do_count = tick;
    end
  end

  // ************************************************************
  // Counter, direction and match conditions
  // ************************************************************
  always_comb begin
    next_cnt = counter_value;
    next_dir = counting_down;
    cond     = 8'h00;
    if (dir_a || dir_b) begin
      next_dir = (dir_a && lvl_a) || (dir_b && lvl_b);
    end else begin
      next_dir = count_down;
    end
    if (dual_counter_enable) begin
      next_dir = 1'b1;
      if (do_count) begin
        // Counter and flag registers are only reinterpreted, never rewritten, on mode change.
        next_cnt[7:0]  = (lo == 8'h00) ? period[7:0] : lo - 8'h01;
        next_cnt[15:8] = (hi == 8'h00) ? period[15:8] : hi - 8'h01;
        cond[FLAG_WRAP] = lo == FLOOR[7:0];
        cond[FLAG_HIGH_BYTE_UNDERFLOW] = hi == FLOOR[7:0];
        cond[FLAG_COMPARE0_IRQ] = lo == compare0_irq[7:0];
        cond[FLAG_CMP1] = lo == cmp1[7:0];
        cond[FLAG_CMP2] = lo == cmp2[7:0];
      end
    end else if (do_count) begin
      if (counting_down) begin
        next_cnt = (counter_value == FLOOR) ? period : counter_value - 16'h0001;
        cond[FLAG_WRAP] = counter_value == FLOOR;
      end else begin
        next_cnt = (counter_value >= period) ? FLOOR : counter_value + 16'h0001;
        cond[FLAG_WRAP] = counter_value == period;
      end
      cond[FLAG_COMPARE0_IRQ] = counter_value == compare0_irq;
      cond[FLAG_CMP1] = counter_value == cmp1;
      cond[FLAG_CMP2] = counter_value == cmp2;
    end
    if (restart) begin
      next_cnt = CNT_RST;
      next_dir = 1'b0;
      cond     = 8'h00;
    end
    if (reset_cmd && !enable) begin
      next_cnt = CNT_RST;
      next_dir = 1'b0;
      cond     = 8'h00;
    end
  end

  // ************************************************************
  // Flags, requests and event pulses
  // ************************************************************
  always_comb begin
    // Set wins over a clear in the same cycle.
    next_flags = (irq_flag_reg & ~flag_clear) | cond;
    if (reset_cmd && !enable) begin
      next_flags = FLAG_RST;
    end
    next_events.wrap           = cond[FLAG_WRAP];
    next_events.high_underflow = cond[FLAG_HIGH_BYTE_UNDERFLOW] && dual_counter_enable;
    next_events.compare        = cond[FLAG_CMP2:FLAG_COMPARE0_IRQ];
  end

  assign irq_request = irq_flag_reg & irq_enable_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= CNT_RST;
      counting_down <= 1'b0;
      irq_flag_reg  <= FLAG_RST;
      events        <= '0;
      prev_a        <= 1'b0;
      prev_b        <= 1'b0;
    end else begin
      counter_value <= next_cnt;
      counting_down <= next_dir;
      irq_flag_reg  <= next_flags;
      events        <= next_events;
      prev_a        <= lvl_a;
      prev_b        <= lvl_b;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_event_flag_tie: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.wrap |-> irq_flag_reg[FLAG_WRAP])
    else $error("wrap event without flag");
  a_high_byte_underflow_dual_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.high_underflow |-> $past(dual_counter_enable))
    else $error("high underflow in sixteen-bit mode");
  a_pulse_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (events.wrap && $past(period) != 16'h0000 && $past(prescale_select) != 3'h0)
    |=> !events.wrap)
    else $error("wrap event longer than a cycle");
  a_irq_request: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq_request == (irq_flag_reg & irq_enable_reg))
    else $error("request not flag and enable");
  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(irq_flag_reg[FLAG_COMPARE0_IRQ]) && !$past(flag_clear[FLAG_COMPARE0_IRQ])
     && !$past(reset_cmd)) |-> irq_flag_reg[FLAG_COMPARE0_IRQ])
    else $error("flag dropped without clear");
  a_dual_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(dual_counter_enable) && !$past(restart) |-> counting_down)
    else $error("dual mode counting up");
  a_dual_no_input: assert property (@(posedge core_clk) disable iff (!rst_n)
    dual_counter_enable |-> !restart && !a_en && !b_en)
    else $error("event input active in dual mode");
  a_hold_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(enable) && !$past(reset_cmd) && !$past(restart)
    |-> $stable(counter_value))
    else $error("counter moved while disabled");

  // Every event pulse must leave its flag behind.
  a_compare0_irq_event_tie: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.compare[0] |-> irq_flag_reg[FLAG_COMPARE0_IRQ])
    else $error("compare 0 event without flag");
  a_cmp1_event_tie: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.compare[1] |-> irq_flag_reg[FLAG_CMP1])
    else $error("compare 1 event without flag");
  a_cmp2_event_tie: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.compare[2] |-> irq_flag_reg[FLAG_CMP2])
    else $error("compare 2 event without flag");
  a_high_byte_underflow_event_tie: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.high_underflow |-> irq_flag_reg[FLAG_HIGH_BYTE_UNDERFLOW])
    else $error("high underflow event without flag");
  a_high_byte_underflow_flag_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(dual_counter_enable) && !$past(irq_flag_reg[FLAG_HIGH_BYTE_UNDERFLOW])
    |-> !irq_flag_reg[FLAG_HIGH_BYTE_UNDERFLOW])
    else $error("high underflow flag in sixteen-bit mode");

  // Counting behaviour in both modes.
  a_dual_low_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(do_count) && $past(dual_counter_enable) && $past(lo) == 8'h00
    && !$past(restart) && !$past(reset_cmd)
    |-> irq_flag_reg[FLAG_WRAP])
    else $error("low underflow flag missing");
  a_dual_high_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(do_count) && $past(dual_counter_enable) && $past(hi) == 8'h00
    && !$past(restart) && !$past(reset_cmd)
    |-> events.high_underflow)
    else $error("high underflow event missing");
  a_up_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(do_count) && !$past(dual_counter_enable) && !$past(counting_down)
    && $past(counter_value) == $past(period) && !$past(restart)
    && !$past(reset_cmd) |-> irq_flag_reg[FLAG_WRAP] && counter_value == FLOOR)
    else $error("no wrap at top");
  a_down_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(do_count) && !$past(dual_counter_enable) && $past(counting_down)
    && $past(counter_value) == FLOOR && !$past(restart) && !$past(reset_cmd)
    |-> irq_flag_reg[FLAG_WRAP] && counter_value == $past(period))
    else $error("no reload at floor");
  a_full_compare: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(do_count) && !$past(dual_counter_enable) && !$past(restart)
    && $past(counter_value) == $past(compare0_irq) && !$past(reset_cmd)
    |-> events.compare[0] && irq_flag_reg[FLAG_COMPARE0_IRQ])
    else $error("compare 0 match missed");
  a_restart_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(restart) |-> counter_value == CNT_RST && !counting_down)
    else $error("restart left counter or direction");
  a_reset_cmd_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(reset_cmd) && !$past(enable) |-> counter_value == CNT_RST
    && irq_flag_reg == FLAG_RST)
    else $error("reset command left state");
  a_clear_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(flag_clear[FLAG_WRAP]) && !$past(cond[FLAG_WRAP])
    |-> !irq_flag_reg[FLAG_WRAP])
    else $error("flag not cleared by write of one");
  a_dir_or: assert property (@(posedge core_clk) disable iff (!rst_n)
    !dual_counter_enable && dir_a && dir_b && !restart && !reset_cmd
    |=> counting_down == ($past(lvl_a) || $past(lvl_b)))
    else $error("direction not the OR of both levels");
  a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    cond[FLAG_COMPARE0_IRQ] |=> irq_flag_reg[FLAG_COMPARE0_IRQ])
    else $error("compare flag not set");
endmodule
`default_nettype wire

// file: sim/tb_tsei_top.sv
// Self-checking bench for the split-mode timer event logic.
`timescale 1ns/1ns
`default_nettype none
module tb_tsei_top
  import tsei_pkg::*;
();
  logic         core_clk, rst_n, enable, dual, down, rcmd;
  logic         ev_a, ev_b, cdown;
  logic [2:0]   sel;
  tsei_event_control_reg_t evc;
  logic [15:0]  period, compare0_irq, cmp1, cmp2, cnt;
  logic [7:0]   ien, fclr, flags, req, c1;
  tsei_events_t ev;
  logic [4:0]   evb;
  int           err_count, samples_checked, n;
  assign evb = ev;

  tsei_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .enable(enable),
    .prescale_select(sel), .dual_counter_enable(dual), .count_down(down),
    .reset_cmd(rcmd), .event_control_reg(evc), .period(period),
    .compare0_irq(compare0_irq), .cmp1(cmp1), .cmp2(cmp2), .event_input_a(ev_a),
    .event_input_b(ev_b), .irq_enable_reg(ien), .flag_clear(fclr),
    .counter_value(cnt), .counting_down(cdown), .irq_flag_reg(flags),
    .irq_request(req), .events(ev));
  tsei_evnet i_net (.core_clk(core_clk), .event_input_a(ev_a),
    .event_input_b(ev_b));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_ev(input int b);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (evb[b] !== 1'b1 && n < 200);
  endtask
  // The first wait only aligns to an event; the second one is measured.
  task automatic span(input int b, input int exp);
    wait_ev(b);
    wait_ev(b);
    check(16'(n), 16'(exp));
  endtask
  // Disable first: the clear command is refused while the counter runs.
  task automatic halt();
    @(posedge core_clk);
    enable <= 1'b0;
    rcmd <= 1'b1;
    repeat (2) @(posedge core_clk);
    rcmd <= 1'b0;
    #1 check(cnt, CNT_RST);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_wrap();
    @(posedge core_clk);
    period <= 16'h0004;
    compare0_irq <= 16'h0002;
    cmp1 <= 16'h0003;
    cmp2 <= 16'h0009;
    enable <= 1'b1;
    wait_ev(4);
    check({15'h0, flags[FLAG_WRAP]}, 16'h0001);
    #10 check({11'h0, evb}, 16'h0000);
    check({8'h0, req}, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      sel <= 3'(s);
      span(4, 5 << s);
    end
    check({8'h0, flags}, 16'h0031);
    $display("test wrap done");
  endtask
  task automatic t_irq();
    @(posedge core_clk);
    enable <= 1'b0;
    ien <= 8'h01;
    repeat (2) @(posedge core_clk);
    #1 check({8'h0, req}, 16'h0001);
    @(posedge core_clk);
    fclr <= 8'h10;
    @(posedge core_clk);
    fclr <= 8'h01;
    #1 check({8'h0, flags}, 16'h0021);
    @(posedge core_clk);
    fclr <= 8'h00;
    ien <= 8'h20;
    #1 check({8'h0, flags}, 16'h0020);
    @(posedge core_clk);
    #1 check({8'h0, req}, 16'h0020);
    $display("test irq done");
  endtask
  task automatic t_down();
    halt();
    check({8'h0, flags}, {8'h0, FLAG_RST});
    down <= 1'b1;
    period <= 16'h0003;
    sel <= 3'h0;
    ien <= 8'h00;
    enable <= 1'b1;
    span(4, 4);
    check({15'h0, flags[FLAG_HIGH_BYTE_UNDERFLOW]}, 16'h0000);
    check({15'h0, cdown}, 16'h0001);
    $display("test down done");
  endtask
  task automatic t_dual();
    halt();
    dual <= 1'b1;
    @(posedge core_clk);
    period <= 16'h0304;
    compare0_irq <= 16'h0002;
    cmp1 <= 16'h0209;
    cmp2 <= 16'h0003;
    down <= 1'b0;
    evc <= {B_RHIGH, 1'b1, A_HIGH, 1'b1};
    i_net.hold(1'b1, 1'b1);
    enable <= 1'b1;
    span(4, 5);
    span(3, 4);
    span(0, 5);
    c1 = cnt[7:0];
    #10 check({8'h0, cnt[7:0]}, (c1 == 0) ? 16'h4 : 16'(c1 - 1));
    check({8'h0, flags}, 16'h0053);
    @(posedge core_clk);
    enable <= 1'b0;
    i_net.hold(1'b0, 1'b0);
    repeat (6) @(posedge core_clk);
    #1 c1 = flags;
    n = cnt;
    dual <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check(cnt, 16'(n));
    check({8'h0, flags}, {8'h0, c1});
    $display("test dual done");
  endtask
  task automatic t_inputs();
    halt();
    period <= 16'hffff;
    enable <= 1'b1;
    evc <= {B_NONE, 1'b0, A_RISE, 1'b1};
    i_net.pulses(1'b0, 3);
    evc <= {B_NONE, 1'b0, A_ANY, 1'b1};
    #1 check(cnt, 16'h0003);
    i_net.pulses(1'b0, 3);
    evc <= {B_RHIGH, 1'b0, A_HIGH, 1'b1};
    #1 check(cnt, 16'h0009);
    i_net.pulses(1'b1, 3);
    evc <= {B_NONE, 1'b0, A_HIGH, 1'b1};
    #1 check(cnt, 16'h0009);
    i_net.hold(1'b1, 1'b0);
    repeat (5) @(posedge core_clk);
    i_net.hold(1'b0, 1'b0);
    repeat (8) @(posedge core_clk);
    #1 check(cnt, 16'h000f);
    evc <= {B_DIR, 1'b1, A_DIR, 1'b1};
    enable <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      i_net.hold(k[0], k[1]);
      repeat (8) @(posedge core_clk);
      #1 check({15'h0, cdown}, 16'h0001);
    end
    i_net.hold(1'b0, 1'b0);
    evc <= {B_RRISE, 1'b1, A_NONE, 1'b0};
    repeat (8) @(posedge core_clk);
    #1 check({15'h0, cdown}, 16'h0000);
    repeat (40) @(posedge core_clk);
    i_net.pulses(1'b1, 1);
    #1 check({15'h0, cnt < 16'h0010}, 16'h0001);
    $display("test inputs done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
  initial begin
    {rst_n, enable, dual, down, rcmd, sel, evc} = '0;
    {period, compare0_irq, cmp1, cmp2, ien, fclr} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 check(cnt, CNT_RST);
    check({flags, req}, {FLAG_RST, 8'h00});
    check({11'h0, evb}, 16'h0000);
    t_wrap();
    t_irq();
    t_down();
    t_dual();
    t_inputs();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: sim/tsei_evnet.sv
// Model of the event routing channels that feed the timer event inputs.
`timescale 1ns/1ns
`default_nettype none
module tsei_evnet (
  // Clock.
  input  wire logic core_clk,
  // Event levels toward the timer.
  output var logic  event_input_a,
  output var logic  event_input_b
);
  initial begin
    event_input_a = 1'b0;
    event_input_b = 1'b0;
  end
  // Levels change just after an edge, as a synchronous channel does.
  task automatic hold(input logic a, input logic b);
    @(posedge core_clk);
    event_input_a <= a;
    event_input_b <= b;
  endtask
  // Each level lasts long enough for the filter and edge stage to settle.
  task automatic pulses(input logic on_b, input int count);
    repeat (count) begin
      hold(!on_b, on_b);
      repeat (3) @(posedge core_clk);
      hold(1'b0, 1'b0);
      repeat (5) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire
